//--- src/lera_pkg.sv
// shared constants and types of the ramp and arithmetic execution unit
// assumes a single 100 MHz clock and a one-cycle 32768 Hz master tick pulse
package lera_pkg;

  // ----------------------------------------------------------------------
  // register offsets and global variable reset value
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_GLOBAL_VAR = 8'h3C;
  localparam logic [7:0] OFS_CONVERTER = 8'h42;
  localparam logic [7:0] OFS_LOCAL_A = 8'h3D;
  localparam logic [7:0] GLOBAL_VAR_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // instruction encodings and field positions
  // ----------------------------------------------------------------------
  localparam logic [3:0] ARITH_PREFIX = 4'h9;
  localparam logic [1:0] ARITH_LOAD = 2'h0;
  localparam logic [1:0] ARITH_ADD_IMM = 2'h1;
  localparam logic [1:0] ARITH_SUB_IMM = 2'h2;
  localparam logic [1:0] ARITH_VAR = 2'h3;
  localparam logic [3:0] VAR_SUBOP_ADD = 4'h0;
  localparam logic [3:0] VAR_SUBOP_SUB = 4'h1;
  localparam logic [5:0] RAMP_VAR_PREFIX = 6'h21;
  localparam int RAMP_IMM_PRESCALE_BIT = 14;
  localparam int RAMP_IMM_DIR_BIT = 8;
  localparam int RAMP_VAR_PRESCALE_BIT = 7;
  localparam int RAMP_VAR_DIR_BIT = 6;

  // ----------------------------------------------------------------------
  // prescaler, level rails and states
  // ----------------------------------------------------------------------
  localparam int MASTER_CLOCK_HZ = 32768;
  localparam int FAST_DIVIDE = 16;
  localparam int SLOW_DIVIDE = 512;
  localparam logic [8:0] PRESCALE_RESET = 9'h000;
  localparam logic [7:0] PWM_MAX = 8'hFF;
  localparam logic [7:0] PWM_MIN = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_STEP = 4'h2,
    ST_FAST = 4'h4,
    ST_FINISH = 4'h8
  } lera_state_e;

endpackage

//--- src/lera_ramp_arith.sv
// ramp and arithmetic execution for one LED program engine
// assumes instructions arrive as a start pulse with the word, registers by plain port
//
// Overview of operation
// - prefix 1001 arithmetic; bits 9:8 load, add, subtract or variable form 0000/0001.
// - ramp starts from current effective level, moving one unit per step.
// - immediate ramp takes prescale from bit 14, step duration from bits 13:9.
// - prescale 0 divides master clock by 16, prescale 1 by 512.
// - each step lasts duration multiplier times the selected prescale tick.
// - zero duration runs the whole sequence inside a single prescale tick.
// - immediate ramp step count comes from bits 7:0, up to 255.
// - level saturates at 0 or 255, remaining steps still timed, never wraps.
// - zero step count leaves level unchanged, lasts as one step.
// - direction bit 0 steps upward, 1 steps downward.
// - variable ramp latches duration and count at start; later changes ignored.
// - variable selectors pick A, B, C or D; D from 0x3C or converter.
// - only five low bits of the variable form the step duration.
// - locals written by instructions only; D written by host at 0x3C.
// - only A readable among locals; D is read and write.
// - log enable bit selects logarithmic curve when 1, linear when 0.
`timescale 1ns/1ns
module lera_ramp_arith
  import lera_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // master timebase
  input wire logic masterTick,
  // instruction issue
  input wire logic [15:0] instr,
  input wire logic instrStart,
  input wire logic [7:0] effPwm,
  // engine control
  input wire logic logEnable,
  input wire logic dFromConverter,
  input wire logic [7:0] converterResult,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // engine outputs
  output logic [7:0] pwmLevel,
  output logic [7:0] dutyOut,
  output logic busy,
  output logic done
);

  typedef struct packed {
    lera_state_e st;
    logic [7:0] varA;
    logic [7:0] varB;
    logic [7:0] varC;
    logic [7:0] varD;
    logic [7:0] pwm;
    logic [7:0] duty;
    logic [7:0] rdData;
    logic [7:0] stepsLeft;
    logic [4:0] stepDur;
    logic [4:0] tickCnt;
    logic dir;
    logic slow;
    logic waitOnly;
    logic busy;
    logic done;
  } lera_ctrl_s;

  lera_ctrl_s s_q, s_d;
  lera_tick_if tickBus ();

  lera_tick_gen u_tick (
    .sys_clk(sys_clk),
    .reset(reset),
    .masterTick(masterTick),
    .ticks(tickBus)
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] pickVar(input logic [1:0] sel, input lera_ctrl_s s,
                                         input logic fromConv, input logic [7:0] conv);
    logic [7:0] v;
    v = s.varA;
    if (sel == 2'h1) begin
      v = s.varB;
    end else if (sel == 2'h2) begin
      v = s.varC;
    end else if (sel == 2'h3) begin
      v = fromConv ? conv : s.varD;
    end
    return v;
  endfunction

  // saturating single-unit step; a level at the rail it steps toward stays there
  function automatic logic [7:0] stepPwm(input logic [7:0] p, input logic down);
    logic [7:0] r;
    r = p;
    if (!down && p != PWM_MAX) begin
      r = p + 8'h01;
    end else if (down && p != PWM_MIN) begin
      r = p - 8'h01;
    end
    return r;
  endfunction

  // squared curve: monotonic, hits both rails, cheap in gates
  function automatic logic [7:0] logMap(input logic [7:0] p);
    logic [15:0] sq;
    sq = 16'(p) * 16'(p) + 16'(p);
    return sq[15:8];
  endfunction

  function automatic lera_ctrl_s writeLocal(input lera_ctrl_s s, input logic [1:0] dst,
                                            input logic [7:0] v);
    lera_ctrl_s r;
    r = s;
    if (dst == 2'h0) begin
      r.varA = v;
    end else if (dst == 2'h1) begin
      r.varB = v;
    end else if (dst == 2'h2) begin
      r.varC = v;
    end
    return r;
  endfunction

  logic tick;
  logic isArith;
  logic isRampImm;
  logic isRampVar;
  logic [7:0] op1;
  logic [7:0] op2;
  logic [7:0] startCount;
  logic [7:0] startDurVar;

  assign tick = s_q.slow ? tickBus.slowTick : tickBus.fastTick;
  assign isArith = (instr[15:12] == ARITH_PREFIX);
  assign isRampImm = !instr[15];
  assign isRampVar = (instr[15:10] == RAMP_VAR_PREFIX);
  assign op1 = pickVar(instr[3:2], s_q, dFromConverter, converterResult);
  assign op2 = pickVar(instr[1:0], s_q, dFromConverter, converterResult);
  assign startDurVar = op1;
  assign startCount = isRampVar ? op2 : instr[7:0];

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (instrStart && isArith) begin
          if (instr[9:8] == ARITH_LOAD) begin
            s_d = writeLocal(s_q, instr[11:10], instr[7:0]);
          end else if (instr[9:8] == ARITH_ADD_IMM) begin
            s_d = writeLocal(s_q, instr[11:10], pickVar(instr[11:10], s_q, 1'b0, 8'h00)
                             + instr[7:0]);
          end else if (instr[9:8] == ARITH_SUB_IMM) begin
            s_d = writeLocal(s_q, instr[11:10], pickVar(instr[11:10], s_q, 1'b0, 8'h00)
                             - instr[7:0]);
          end else if (instr[7:4] == VAR_SUBOP_ADD) begin
            s_d = writeLocal(s_q, instr[11:10], op1 + op2);
          end else if (instr[7:4] == VAR_SUBOP_SUB) begin
            s_d = writeLocal(s_q, instr[11:10], op1 - op2);
          end
          s_d.done = 1'b1;
        end else if (instrStart && (isRampImm || isRampVar)) begin
          s_d.pwm = effPwm;
          s_d.busy = 1'b1;
          s_d.tickCnt = 5'h00;
          // operands are captured here and never looked at again
          if (isRampVar) begin
            s_d.slow = instr[RAMP_VAR_PRESCALE_BIT];
            s_d.dir = instr[RAMP_VAR_DIR_BIT];
            s_d.stepDur = startDurVar[4:0];
          end else begin
            s_d.slow = instr[RAMP_IMM_PRESCALE_BIT];
            s_d.dir = instr[RAMP_IMM_DIR_BIT];
            s_d.stepDur = instr[13:9];
          end
          s_d.waitOnly = (startCount == 8'h00);
          s_d.stepsLeft = (startCount == 8'h00) ? 8'h01 : startCount;
          if (s_d.stepDur != 5'h00) begin
            s_d.st = ST_STEP;
          end else if (startCount == 8'h00) begin
            s_d.st = ST_FINISH;
          end else begin
            s_d.st = ST_FAST;
          end
        end
      end
      ST_STEP: begin
        if (tick) begin
          if (s_q.tickCnt == s_q.stepDur - 5'h01) begin
            s_d.tickCnt = 5'h00;
            if (!s_q.waitOnly) begin
              s_d.pwm = stepPwm(s_q.pwm, s_q.dir);
            end
            if (s_q.stepsLeft == 8'h01) begin
              s_d.st = ST_IDLE;
              s_d.busy = 1'b0;
              s_d.done = 1'b1;
            end else begin
              s_d.stepsLeft = s_q.stepsLeft - 8'h01;
            end
          end else begin
            s_d.tickCnt = s_q.tickCnt + 5'h01;
          end
        end
      end
      ST_FAST: begin
        // all steps go out at core rate, then the ramp waits out one tick
        s_d.pwm = stepPwm(s_q.pwm, s_q.dir);
        s_d.stepsLeft = s_q.stepsLeft - 8'h01;
        if (s_q.stepsLeft == 8'h01) begin
          s_d.st = ST_FINISH;
        end
      end
      ST_FINISH: begin
        if (tick) begin
          s_d.st = ST_IDLE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
    if (regWrite && regAddr == OFS_GLOBAL_VAR) begin
      s_d.varD = regWrData;
    end
    if (regAddr == OFS_GLOBAL_VAR) begin
      s_d.rdData = s_q.varD;
    end else if (regAddr == OFS_LOCAL_A) begin
      s_d.rdData = s_q.varA;
    end else if (regAddr == OFS_CONVERTER) begin
      s_d.rdData = converterResult;
    end else begin
      s_d.rdData = 8'h00;
    end
    s_d.duty = logEnable ? logMap(s_d.pwm) : s_d.pwm;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '{st: ST_IDLE, varD: GLOBAL_VAR_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rdData;
  assign pwmLevel = s_q.pwm;
  assign dutyOut = s_q.duty;
  assign busy = s_q.busy;
  assign done = s_q.done;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_single_unit: assert property (s_q.st != ST_IDLE && $past(s_q.st) != ST_IDLE |->
    (s_q.pwm == $past(s_q.pwm) || s_q.pwm - $past(s_q.pwm) == 8'h01
     || $past(s_q.pwm) - s_q.pwm == 8'h01))
    else $error("ramp moved by more than one unit");
  a_no_wrap: assert property (s_q.busy && $past(s_q.busy) && $past(s_q.pwm) == PWM_MAX
    && !s_q.dir |-> s_q.pwm == PWM_MAX)
    else $error("ramp wrapped past full scale");
  a_up_dir: assert property (s_q.busy && $past(s_q.busy) && !s_q.dir |->
    s_q.pwm >= $past(s_q.pwm))
    else $error("upward ramp went down");
  a_down_dir: assert property (s_q.busy && $past(s_q.busy) && s_q.dir |->
    s_q.pwm <= $past(s_q.pwm))
    else $error("downward ramp went up");
  a_wait_hold: assert property (s_q.busy && s_q.waitOnly |=> $stable(s_q.pwm))
    else $error("zero-count ramp changed level");
  a_operand_latch: assert property (s_q.busy && $past(s_q.busy) |->
    $stable(s_q.stepDur) && $stable(s_q.dir) && $stable(s_q.slow))
    else $error("ramp operands changed while running");
  a_load_local: assert property (s_q.st == ST_IDLE && instrStart && isArith
    && instr[9:8] == ARITH_LOAD && instr[11:10] == 2'h0 |=> s_q.varA == $past(instr[7:0]))
    else $error("load did not set variable A");
  a_global_write: assert property (regWrite && regAddr == OFS_GLOBAL_VAR |=>
    s_q.varD == $past(regWrData) ##1
    ($past(regAddr) != OFS_GLOBAL_VAR || regRdData == $past(s_q.varD)))
    else $error("global variable write lost");
  a_read_a: assert property (regAddr == OFS_LOCAL_A |=> regRdData == $past(s_q.varA))
    else $error("variable A read mismatch");
  a_duty_map: assert property (dutyOut ==
    ($past(logEnable) ? logMap(pwmLevel) : pwmLevel))
    else $error("duty curve mismatch");
  a_fast_bound: assert property (s_q.st == ST_IDLE ##1 s_q.st == ST_FAST |->
    ##[1:256] s_q.st == ST_FINISH)
    else $error("fast ramp overran");

  c_step_ramp: cover property (s_q.st == ST_STEP ##1 s_q.done);
  c_fast_ramp: cover property (s_q.st == ST_FAST ##1 s_q.st == ST_FINISH);
  c_saturate: cover property (s_q.busy && s_q.pwm == PWM_MAX && !s_q.dir);
  c_var_ramp: cover property (s_q.st == ST_IDLE && instrStart && isRampVar);

endmodule

//--- src/lera_tick_gen.sv
// divides the 32768 Hz master tick by 16 and by 512
// assumes masterTick is a one-cycle pulse synchronous to sys_clk
`timescale 1ns/1ns
module lera_tick_gen
  import lera_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // master timebase
  input wire logic masterTick,
  // ticks out
  lera_tick_if.gen ticks
);

  typedef struct packed {
    logic [8:0] div;
    logic fast;
    logic slow;
  } lera_tick_s;

  lera_tick_s tick_q, tick_d;

  // the slow tick lands on a fast tick so both timebases stay aligned
  always_comb begin
    tick_d = tick_q;
    tick_d.fast = 1'b0;
    tick_d.slow = 1'b0;
    if (masterTick) begin
      tick_d.div = tick_q.div + 9'h001;
      tick_d.fast = (tick_q.div[3:0] == 4'(FAST_DIVIDE - 1));
      tick_d.slow = (tick_q.div == 9'(SLOW_DIVIDE - 1));
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tick_q <= '{div: PRESCALE_RESET, fast: 1'b0, slow: 1'b0};
    end else begin
      tick_q <= tick_d;
    end
  end

  assign ticks.fastTick = tick_q.fast;
  assign ticks.slowTick = tick_q.slow;

  a_slow_on_fast: assert property (@(posedge sys_clk) disable iff (reset)
    tick_q.slow |-> tick_q.fast)
    else $error("slow tick not aligned to fast tick");

endmodule

//--- src/lera_tick_if.sv
// prescaler ticks passed from the tick generator to the execution unit
// assumes both ends run on the same sys_clk
`timescale 1ns/1ns
interface lera_tick_if;
  logic fastTick;
  logic slowTick;
  modport gen (output fastTick, output slowTick);
  modport user (input fastTick, input slowTick);
endinterface

//--- tb/tb_lera_ramp_arith.sv
// self-checking bench for the ramp and arithmetic execution unit
// assumes masterTick pulses every 2 cycles, so fast tick = 32 and slow tick = 1024 cycles
`timescale 1ns/1ns
module tb_lera_ramp_arith;
  import lera_pkg::*;
  // ----------------------------------------------------------------------
  // stimulus and dut
  // ----------------------------------------------------------------------
  logic sys_clk = 1'b0, reset = 1'b1, masterTick = 1'b0, instrStart = 1'b0;
  logic logEnable = 1'b0, dFromConverter = 1'b0, regWrite = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [7:0] effPwm = 8'h00, converterResult = 8'hA5, regAddr = 8'h00, regWrData = 8'h00;
  logic [7:0] regRdData, pwmLevel, dutyOut;
  logic busy, done;
  int fails = 0, n_checks = 0, cyc = 0;
  localparam logic [15:0] RI [7] = '{16'h0202, 16'h0303, 16'h0203, 16'h0200, 16'h0005,
                                     16'h4202, 16'h0601};
  localparam logic [7:0] RE [7] = '{8'h0A, 8'h01, 8'hFE, 8'h40, 8'h20, 8'h80, 8'h10};
  localparam logic [7:0] RX [7] = '{8'h0C, 8'h00, 8'hFF, 8'h40, 8'h25, 8'h82, 8'h11};
  localparam int LO [7] = '{32, 64, 64, 0, 4, 1024, 64};
  localparam int HI [7] = '{68, 100, 100, 36, 40, 2052, 100};
  localparam logic [15:0] AI [11] = '{16'h9010, 16'h9105, 16'h9220, 16'h9403, 16'h9301,
                                      16'h9311, 16'h9321, 16'h9C55, 16'h9807, 16'h9302,
                                      16'h930F};
  localparam logic [7:0] AX [11] = '{8'h10, 8'h15, 8'hF5, 8'hF5, 8'hF8, 8'hF5, 8'hF5, 8'hF5,
                                     8'hF5, 8'hFC, 8'hAA};

  always #5 sys_clk = ~sys_clk;
  // timebase runs free, as it would from the master oscillator
  always @(negedge sys_clk) masterTick <= ~masterTick;

  lera_ramp_arith dut (
    .sys_clk(sys_clk), .reset(reset), .masterTick(masterTick), .instr(instr),
    .instrStart(instrStart), .effPwm(effPwm), .logEnable(logEnable),
    .dFromConverter(dFromConverter), .converterResult(converterResult), .regAddr(regAddr),
    .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData), .pwmLevel(pwmLevel),
    .dutyOut(dutyOut), .busy(busy), .done(done)
  );

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic regWr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(negedge sys_clk);
    regWrite = 1'b0;
  endtask

  task automatic regRd(input logic [7:0] a, input logic [7:0] exp, input string what);
    regAddr = a;
    @(negedge sys_clk);
    chk(what, {8'h00, regRdData}, {8'h00, exp});
  endtask

  task automatic go(input logic [15:0] i, input logic [7:0] e);
    cyc = 0;
    instr = i;
    effPwm = e;
    instrStart = 1'b1;
    @(negedge sys_clk);
    instrStart = 1'b0;
  endtask

  // bounded wait; cyc keeps counting from go
  task automatic waitDone();
    while (done !== 1'b1) begin
      cyc++;
      if (cyc > 5000) begin
        fails++;
        end_sim();
      end
      @(negedge sys_clk);
    end
  endtask

  function automatic logic [15:0] inRange(input int lo, input int hi);
    return {15'h0000, (cyc > lo && cyc <= hi)};
  endfunction

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    chk("reset outs", {pwmLevel, dutyOut}, 16'h0000);
    chk("reset flags", {14'h0000, busy, done}, 16'h0000);
    regRd(OFS_GLOBAL_VAR, GLOBAL_VAR_RESET, "d reset");
    $display("test reset finished");

    regWr(OFS_GLOBAL_VAR, 8'h55);
    regRd(OFS_GLOBAL_VAR, 8'h55, "d rw");
    regRd(OFS_CONVERTER, 8'hA5, "converter");
    regWr(OFS_LOCAL_A, 8'h66);
    regRd(OFS_LOCAL_A, 8'h00, "a not host writable");
    regRd(8'h10, 8'h00, "unmapped");
    $display("test registers finished");

    for (int k = 0; k < 11; k++) begin
      go(AI[k], 8'h00);
      waitDone();
      chk("arith latency", {15'h0000, cyc <= 3}, 16'h0001);
      regRd(OFS_LOCAL_A, AX[k], "arith a");
    end
    $display("test arithmetic finished");

    for (int k = 0; k < 7; k++) begin
      go(RI[k], RE[k]);
      waitDone();
      chk("ramp level", {8'h00, pwmLevel}, {8'h00, RX[k]});
      chk("ramp time", inRange(LO[k], HI[k]), 16'h0001);
    end
    $display("test immediate ramps finished");

    // count from A, duration from D whose bit 5 must be dropped
    go(16'h9003, 8'h00);
    waitDone();
    regWr(OFS_GLOBAL_VAR, 8'h22);
    go(16'h840C, 8'h50);
    chk("busy", {15'h0000, busy}, 16'h0001);
    regWr(OFS_GLOBAL_VAR, 8'h01);
    instr = 16'h9077;
    instrStart = 1'b1;
    @(negedge sys_clk);
    instrStart = 1'b0;
    cyc += 2;
    waitDone();
    chk("var ramp level", {8'h00, pwmLevel}, 16'h0053);
    chk("var ramp time", inRange(160, 200), 16'h0001);
    regRd(OFS_LOCAL_A, 8'h03, "start while busy");
    regRd(OFS_GLOBAL_VAR, 8'h01, "d after write");
    $display("test variable ramp finished");

    chk("linear duty", {8'h00, dutyOut}, 16'h0053);
    logEnable = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("log duty", {8'h00, dutyOut}, 16'h001B);
    logEnable = 1'b0;
    $display("test curve finished");

    dFromConverter = 1'b1;
    converterResult = 8'h01;
    go(16'h840C, 8'h10);
    waitDone();
    chk("conv ramp level", {8'h00, pwmLevel}, 16'h0013);
    chk("conv ramp time", inRange(64, 104), 16'h0001);
    dFromConverter = 1'b0;
    $display("test converter source finished");
    end_sim();
  end
endmodule
